// ### core/sarc_top.sv
// status groups, interface messages and waveform block receiver
// Function
// - filter 1: rising condition sets event
// - filter 0: falling condition sets event
// - device clear empties buffers, status, request
// - remote enable enters remote state
// - go to local returns local state
// - local lockout enters lockout state
// - lockout ignores panel local key
// - wrong block length flags an error
// - ascending words, upper byte first
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`include "sarc_params.svh"
module sarc_top #(
    parameter int WAVE_WORDS = `SARC_WAVE_WORDS,
    parameter int COND_W = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [`SARC_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`SARC_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [COND_W-1:0] oper_cond_in,
    input wire logic [COND_W-1:0] ovld_cond_in,
    input wire logic panel_local_key,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    output logic rx_ready,
    output logic [15:0] wave_word,
    output logic [9:0] wave_index,
    output logic wave_we,
    output logic remote_mode,
    output logic lockout_mode,
    output logic io_flush,
    output logic irq
);
    typedef struct packed {
        logic aw_hold;
        logic [`SARC_ADDR_W-1:0] awaddr;
        logic w_hold;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [COND_W-1:0] oper_filt;
        logic [COND_W-1:0] ovld_filt;
        logic [COND_W-1:0] oper_clr;
        logic [COND_W-1:0] ovld_clr;
        sarc_pkg::sarc_rstate_type rstate;
        logic [2:0] key_sync;
        sarc_pkg::sarc_wstate_type wstate;
        logic [7:0] hi_byte;
        logic [10:0] wcount;
        logic [15:0] wave_word;
        logic wave_we;
        logic io_flush;
        logic [`SARC_IRQ_W-1:0] irq_stat;
        logic [`SARC_IRQ_W-1:0] irq_mask;
        logic irq;
        logic awready;
        logic wready;
        logic arready;
        logic rx_ready;
        logic [9:0] wave_index;
        logic remote_mode;
        logic lockout_mode;
    } sarc_st_type;
    sarc_st_type st_reg, st_next;
    logic [COND_W-1:0] oper_evt, ovld_evt, oper_cond, ovld_cond;
    logic oper_fired, ovld_fired;

    sarc_filter #(.W(COND_W)) u_oper (
        .clk(clk),
        .resetn(resetn),
        .cond_in(oper_cond_in),
        .filt(st_reg.oper_filt),
        .evt_clr(st_reg.oper_clr),
        .evt(oper_evt),
        .cond_now(oper_cond),
        .fired(oper_fired)
    );
    sarc_filter #(.W(COND_W)) u_ovld (
        .clk(clk),
        .resetn(resetn),
        .cond_in(ovld_cond_in),
        .filt(st_reg.ovld_filt),
        .evt_clr(st_reg.ovld_clr),
        .evt(ovld_evt),
        .cond_now(ovld_cond),
        .fired(ovld_fired)
    );

    function automatic logic [31:0] sarc_ext(input logic [COND_W-1:0] v);
        sarc_ext = 32'(v);
    endfunction

    logic do_wr, do_rd, key_edge, sdc, ifc, w_take;
    logic [`SARC_IRQ_W-1:0] ev;
    logic [31:0] rd;
    logic rd_ok;
    always_comb begin
        st_next = st_reg;
        st_next.wave_we = 1'b0;
        st_next.io_flush = 1'b0;
        st_next.oper_clr = '0;
        st_next.ovld_clr = '0;
        ev = '0;
        rd = 32'h0;
        rd_ok = 1'b1;
        sdc = 1'b0;
        ifc = 1'b0;
        // axi write: address and data taken in either order
        if (s_axi_awvalid && !st_reg.aw_hold && !st_reg.bvalid) begin
            st_next.aw_hold = 1'b1;
            st_next.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_reg.w_hold && !st_reg.bvalid) begin
            st_next.w_hold = 1'b1;
            st_next.wdata = s_axi_wdata;
        end
        do_wr = st_reg.aw_hold && st_reg.w_hold && !st_reg.bvalid;
        if (do_wr) begin
            st_next.aw_hold = 1'b0;
            st_next.w_hold = 1'b0;
            st_next.bvalid = 1'b1;
            st_next.bresp = `SARC_RESP_OKAY;
            case (st_reg.awaddr)
                `SARC_OFF_CTRL: begin
                    ifc = st_reg.wdata[`SARC_CTRL_IFC];
                    sdc = st_reg.wdata[`SARC_CTRL_SDC];
                    if (st_reg.wdata[`SARC_CTRL_REN] && st_reg.rstate == sarc_pkg::SARC_LOCAL) begin
                        st_next.rstate = sarc_pkg::SARC_REMOTE;
                    end
                    if (st_reg.wdata[`SARC_CTRL_LLO]) begin
                        st_next.rstate = sarc_pkg::SARC_LOCKOUT;
                    end
                    if (st_reg.wdata[`SARC_CTRL_GTL]) begin
                        st_next.rstate = sarc_pkg::SARC_LOCAL;
                    end
                    if (st_reg.wdata[`SARC_CTRL_LOAD]) begin
                        // block follows the command part as a separate transfer
                        st_next.wstate = sarc_pkg::SARC_W_HIGH;
                        st_next.wcount = '0;
                    end
                    if (st_reg.wdata[`SARC_CTRL_END] && st_reg.wstate != sarc_pkg::SARC_W_IDLE) begin
                        st_next.wstate = sarc_pkg::SARC_W_IDLE;
                        if (st_reg.wstate == sarc_pkg::SARC_W_LOW ||
                            st_reg.wcount != 11'(WAVE_WORDS)) begin
                            ev[`SARC_IRQ_WERR] = 1'b1;
                        end else begin
                            ev[`SARC_IRQ_WDONE] = 1'b1;
                        end
                    end
                end
                `SARC_OFF_OPER_FILT: st_next.oper_filt = st_reg.wdata[COND_W-1:0];
                `SARC_OFF_OVLD_FILT: st_next.ovld_filt = st_reg.wdata[COND_W-1:0];
                `SARC_OFF_OPER_EVT: st_next.oper_clr = st_reg.wdata[COND_W-1:0];
                `SARC_OFF_OVLD_EVT: st_next.ovld_clr = st_reg.wdata[COND_W-1:0];
                `SARC_OFF_IRQ_STAT: st_next.irq_stat = st_reg.irq_stat & ~st_reg.wdata[`SARC_IRQ_W-1:0];
                `SARC_OFF_IRQ_MASK: st_next.irq_mask = st_reg.wdata[`SARC_IRQ_W-1:0];
                default: st_next.bresp = `SARC_RESP_SLVERR;
            endcase
        end
        if (st_reg.bvalid && s_axi_bready) begin
            st_next.bvalid = 1'b0;
        end
        // axi read: event registers clear on read
        do_rd = s_axi_arvalid && !st_reg.rvalid;
        case (s_axi_araddr)
            `SARC_OFF_STATE: rd = {26'h0, st_reg.wstate, st_reg.rstate, st_reg.key_sync[2], 1'b0};
            `SARC_OFF_OPER_COND: rd = sarc_ext(oper_cond);
            `SARC_OFF_OPER_FILT: rd = sarc_ext(st_reg.oper_filt);
            `SARC_OFF_OPER_EVT: rd = sarc_ext(oper_evt);
            `SARC_OFF_OVLD_COND: rd = sarc_ext(ovld_cond);
            `SARC_OFF_OVLD_FILT: rd = sarc_ext(st_reg.ovld_filt);
            `SARC_OFF_OVLD_EVT: rd = sarc_ext(ovld_evt);
            `SARC_OFF_IRQ_STAT: rd = 32'(st_reg.irq_stat);
            `SARC_OFF_IRQ_MASK: rd = 32'(st_reg.irq_mask);
            `SARC_OFF_WAVE_CNT: rd = 32'(st_reg.wcount);
            `SARC_OFF_CTRL: rd = 32'h0;
            default: rd_ok = 1'b0;
        endcase
        if (do_rd) begin
            st_next.rvalid = 1'b1;
            st_next.rdata = rd;
            st_next.rresp = rd_ok ? `SARC_RESP_OKAY : `SARC_RESP_SLVERR;
            if (s_axi_araddr == `SARC_OFF_OPER_EVT) begin
                st_next.oper_clr = oper_evt;
            end
            if (s_axi_araddr == `SARC_OFF_OVLD_EVT) begin
                st_next.ovld_clr = ovld_evt;
            end
        end
        if (st_reg.rvalid && s_axi_rready) begin
            st_next.rvalid = 1'b0;
        end
        // panel key: three stages, rising edge when second is high and third still low
        st_next.key_sync = {st_reg.key_sync[1:0], panel_local_key};
        key_edge = st_reg.key_sync[1] && !st_reg.key_sync[2];
        // lockout never matches here, so the key is ignored there
        if (key_edge && st_reg.rstate == sarc_pkg::SARC_REMOTE) begin
            st_next.rstate = sarc_pkg::SARC_LOCAL;
        end
        // waveform byte stream, upper byte then lower, ascending index
        w_take = rx_valid && st_reg.wstate != sarc_pkg::SARC_W_IDLE;
        if (w_take) begin
            case (st_reg.wstate)
                sarc_pkg::SARC_W_HIGH: begin
                    st_next.hi_byte = rx_byte;
                    st_next.wstate = sarc_pkg::SARC_W_LOW;
                end
                sarc_pkg::SARC_W_LOW: begin
                    st_next.wave_word = {st_reg.hi_byte, rx_byte};
                    st_next.wave_we = st_reg.wcount < 11'(WAVE_WORDS);
                    st_next.wave_index = 10'(st_reg.wcount);
                    st_next.wcount = st_reg.wcount + 11'h1;
                    st_next.wstate = sarc_pkg::SARC_W_HIGH;
                end
                default: st_next.wstate = sarc_pkg::SARC_W_IDLE;
            endcase
        end
        if (sdc) begin
            st_next.io_flush = 1'b1;
            st_next.wstate = sarc_pkg::SARC_W_IDLE;
            st_next.wcount = '0;
            st_next.oper_clr = '1;
            st_next.ovld_clr = '1;
            st_next.irq_stat = '0;
        end
        if (ifc) begin
            st_next.wstate = sarc_pkg::SARC_W_IDLE;
            st_next.wcount = '0;
            st_next.io_flush = 1'b1;
        end
        // events set after clears so an event in the clear cycle survives
        ev[`SARC_IRQ_OPER] = oper_fired;
        ev[`SARC_IRQ_OVLD] = ovld_fired;
        st_next.irq_stat = st_next.irq_stat | ev;
        st_next.irq = |(st_next.irq_stat & st_next.irq_mask);
        // readies and modes registered from the next state: same timing, but every port is a flop
        st_next.awready = !st_next.aw_hold && !st_next.bvalid;
        st_next.wready = !st_next.w_hold && !st_next.bvalid;
        st_next.arready = !st_next.rvalid;
        st_next.rx_ready = st_next.wstate != sarc_pkg::SARC_W_IDLE;
        st_next.remote_mode = st_next.rstate != sarc_pkg::SARC_LOCAL;
        st_next.lockout_mode = st_next.rstate == sarc_pkg::SARC_LOCKOUT;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
            st_reg.oper_filt <= COND_W'(`SARC_FILT_RESET);
            st_reg.ovld_filt <= COND_W'(`SARC_FILT_RESET);
            st_reg.rstate <= sarc_pkg::SARC_LOCAL;
            st_reg.wstate <= sarc_pkg::SARC_W_IDLE;
            st_reg.awready <= 1'b1;
            st_reg.wready <= 1'b1;
            st_reg.arready <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready = st_reg.wready;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign rx_ready = st_reg.rx_ready;
    assign wave_word = st_reg.wave_word;
    assign wave_index = st_reg.wave_index;
    assign wave_we = st_reg.wave_we;
    assign remote_mode = st_reg.remote_mode;
    assign lockout_mode = st_reg.lockout_mode;
    assign io_flush = st_reg.io_flush;
    assign irq = st_reg.irq;
endmodule

// ### include/sarc_params.svh
// constants for the status and remote control block
`ifndef SARC_PARAMS_SVH
`define SARC_PARAMS_SVH
`define SARC_ADDR_W 8
`define SARC_OFF_CTRL 8'h00
`define SARC_OFF_STATE 8'h04
`define SARC_OFF_OPER_COND 8'h08
`define SARC_OFF_OPER_FILT 8'h0C
`define SARC_OFF_OPER_EVT 8'h10
`define SARC_OFF_OVLD_COND 8'h14
`define SARC_OFF_OVLD_FILT 8'h18
`define SARC_OFF_OVLD_EVT 8'h1C
`define SARC_OFF_IRQ_STAT 8'h20
`define SARC_OFF_IRQ_MASK 8'h24
`define SARC_OFF_WAVE_CNT 8'h28
`define SARC_CTRL_IFC 0
`define SARC_CTRL_SDC 1
`define SARC_CTRL_REN 2
`define SARC_CTRL_GTL 3
`define SARC_CTRL_LLO 4
`define SARC_CTRL_LOAD 5
`define SARC_CTRL_END 6
`define SARC_IRQ_OPER 0
`define SARC_IRQ_OVLD 1
`define SARC_IRQ_WDONE 2
`define SARC_IRQ_WERR 3
`define SARC_IRQ_W 4
`define SARC_WAVE_WORDS 1024
`define SARC_FILT_RESET 16'hFFFF
`define SARC_RESP_OKAY 2'h0
`define SARC_RESP_SLVERR 2'h2
`endif

// ### include/sarc_pkg.sv
// types for the status and remote control block
package sarc_pkg;
    typedef enum logic [1:0] {
        SARC_LOCAL = 2'b00,
        SARC_REMOTE = 2'b01,
        SARC_LOCKOUT = 2'b10
    } sarc_rstate_type;
    typedef enum logic [1:0] {
        SARC_W_IDLE = 2'b00,
        SARC_W_HIGH = 2'b01,
        SARC_W_LOW = 2'b10
    } sarc_wstate_type;
    typedef struct packed {
        logic [15:0] cond;
        logic [15:0] filt;
        logic [15:0] evt;
    } sarc_tf_type;
endpackage

// ### core/sarc_filter.sv
// transition filter turning condition changes into latched events
`include "sarc_params.svh"
module sarc_filter #(
    parameter int W = 16
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [W-1:0] cond_in,
    input wire logic [W-1:0] filt,
    input wire logic [W-1:0] evt_clr,
    output logic [W-1:0] evt,
    output logic [W-1:0] cond_now,
    output logic fired
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] evt;
        logic fired;
    } sarc_filt_st_type;
    sarc_filt_st_type st_reg, st_next;
    logic [W-1:0] rise, fall, hit;
    always_comb begin
        st_next = st_reg;
        st_next.s1 = cond_in;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        // only the agreed (s2/s3) stages are compared
        rise = st_reg.s2 & ~st_reg.s3;
        fall = ~st_reg.s2 & st_reg.s3;
        hit = (filt & rise) | (~filt & fall);
        // set wins over clear; bits stay until cleared
        st_next.evt = (st_reg.evt & ~evt_clr) | hit;
        st_next.fired = |hit;
    end
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign evt = st_reg.evt;
    assign cond_now = st_reg.s3;
    assign fired = st_reg.fired;
endmodule

// ### tb/sarc_checker.sv
// port assertions for the status and remote control block
`include "sarc_params.svh"
module sarc_checker (
    input wire logic clk,
    input wire logic resetn,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic wave_we,
    input wire logic lockout_mode,
    input wire logic io_flush
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    chk_write_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    chk_rd_slverr: assert property (s_axi_rvalid && s_axi_rresp == `SARC_RESP_SLVERR |-> s_axi_rdata == 32'h0)
        else $error("error read carries data");
    chk_word_pulse: assert property (wave_we |=> !wave_we)
        else $error("word write longer than one cycle");
    chk_word_cause: assert property (wave_we |-> $past(rx_valid && rx_ready))
        else $error("word write without a low byte");
    chk_flush_pulse: assert property (io_flush |=> !io_flush)
        else $error("flush longer than one cycle");
    // only a register write may end lockout, never the panel key
    chk_lock_hold: assert property ($fell(lockout_mode) |-> s_axi_bvalid || $past(s_axi_bvalid) || !s_axi_awready)
        else $error("lockout left without a write");
endmodule

bind sarc_top sarc_checker i_chk (.clk(clk), .resetn(resetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .rx_valid(rx_valid), .rx_ready(rx_ready),
    .wave_we(wave_we), .lockout_mode(lockout_mode), .io_flush(io_flush));

// ### tb/sarc_host_model.sv
// host model streaming waveform bytes into the block
module sarc_host_model (
    input wire logic clk,
    input wire logic rx_ready,
    output logic [7:0] rx_byte,
    output logic rx_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    int gap = 0;
    int hangs = 0;
    initial begin
        rx_byte = 8'h00;
        rx_valid = 1'b0;
    end
    task automatic send_word(input logic [15:0] w);
        send_byte(w[15:8]);
        send_byte(w[7:0]);
    endtask
    task automatic send_byte(input logic [7:0] b);
        int i;
        @(posedge clk);
        rx_byte <= b;
        rx_valid <= 1'b1;
        for (i = 0; i < 200; i++) begin
            @(posedge clk);
            if (rx_ready) break;
        end
        if (i == 200) hangs++;
        rx_valid <= 1'b0;
        // a released line must not keep showing the byte
        rx_byte <= ~b;
        repeat (gap) @(posedge clk);
    endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench for the status and remote control block
`include "sarc_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, resetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, key = 0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, rx_byte;
    logic [31:0] wdata = 32'h0, rdata;
    logic [15:0] oper_c = 16'h0, ovld_c = 16'h0, wave_word;
    logic awr, wrdy, bvalid, arr, rvalid, rx_valid, rx_ready, we, rem, lock, flush, irq;
    logic [1:0] bresp, rresp;
    logic [9:0] wave_index;
    logic [25:0] wq[$];
    logic [15:0] wvq[4];
    int errors = 0, n_checks = 0, seed = 35, n_flush = 0;
    logic [31:0] op[6] = '{32'h04, 32'h00, 32'h04, 32'h10, 32'h00, 32'h08};
    logic el[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    logic erm[6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    always #5 clk = ~clk;
    sarc_top #(.WAVE_WORDS(4), .COND_W(16)) i_dut (.clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wrdy), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .oper_cond_in(oper_c),
        .ovld_cond_in(ovld_c), .panel_local_key(key), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .rx_ready(rx_ready), .wave_word(wave_word), .wave_index(wave_index), .wave_we(we),
        .remote_mode(rem), .lockout_mode(lock), .io_flush(flush), .irq(irq));
    sarc_host_model i_host (.clk(clk), .rx_ready(rx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid));
    always @(posedge clk) begin
        if (we) wq.push_back({wave_index, wave_word});
        if (flush) n_flush++;
    end
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int i);
        if (i >= 100) begin
            chk(32'h1, 32'h0);
            print_verdict;
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int i;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wrdy) wv <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        tmo(i);
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int i;
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 100; i++) begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        tmo(i);
        chk(rdata, e);
        chk(32'(rresp), 32'(er));
    endtask
    // conditions pass a three-flop synchroniser, so allow it time to settle
    task automatic setc(input int g, input logic [15:0] v);
        @(posedge clk);
        if (g != 0) ovld_c <= v;
        else oper_c <= v;
        repeat (8) @(posedge clk);
    endtask
    function automatic logic [15:0] tf(input logic [15:0] f, input logic [15:0] a, input logic [15:0] b);
        return (f & ~a & b) | (~f & a & ~b);
    endfunction
    initial begin
        logic [15:0] f, c0, c1, c2, ex;
        logic [7:0] b;
        int g, k;
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        rdc(`SARC_OFF_OPER_FILT, 32'h0000FFFF, `SARC_RESP_OKAY);
        rdc(8'h80, 32'h0, `SARC_RESP_SLVERR);
        axw(8'h80, 32'h0, `SARC_RESP_SLVERR);
        $display("test registers done");
        for (g = 0; g < 2; g++) begin
            f = 16'($random(seed));
            c0 = 16'($random(seed));
            c1 = 16'($random(seed));
            c2 = 16'($random(seed));
            b = (g != 0) ? `SARC_OFF_OVLD_COND : `SARC_OFF_OPER_COND;
            axw(b + 8'h04, {16'h0, f}, `SARC_RESP_OKAY);
            setc(g, c0);
            rdc(b + 8'h08, {16'h0, tf(f, 16'h0, c0)}, `SARC_RESP_OKAY);
            axw(`SARC_OFF_IRQ_STAT, 32'hF, `SARC_RESP_OKAY);
            setc(g, c1);
            setc(g, c2);
            ex = tf(f, c0, c1) | tf(f, c1, c2);
            rdc(b, {16'h0, c2}, `SARC_RESP_OKAY);
            rdc(`SARC_OFF_IRQ_STAT, {31'h0, ex != 16'h0} << g, `SARC_RESP_OKAY);
            axw(`SARC_OFF_IRQ_MASK, 32'h0, `SARC_RESP_OKAY);
            chk(32'(irq), 32'h0);
            axw(`SARC_OFF_IRQ_MASK, 32'hF, `SARC_RESP_OKAY);
            chk(32'(irq), 32'(ex != 16'h0));
            rdc(b + 8'h08, {16'h0, ex}, `SARC_RESP_OKAY);
            rdc(b + 8'h08, 32'h0, `SARC_RESP_OKAY);
            axw(`SARC_OFF_IRQ_STAT, 32'hF, `SARC_RESP_OKAY);
            @(posedge clk);
            chk(32'(irq), 32'h0);
        end
        $display("test filters done");
        for (k = 0; k < 6; k++) begin
            if (op[k] == 32'h0) begin
                key <= 1'b1;
                repeat (8) @(posedge clk);
                key <= 1'b0;
                repeat (8) @(posedge clk);
            end else axw(`SARC_OFF_CTRL, op[k], `SARC_RESP_OKAY);
            repeat (2) @(posedge clk);
            chk(32'(lock), 32'(el[k]));
            if (!el[k]) chk(32'(rem), 32'(erm[k]));
        end
        $display("test remote states done");
        setc(0, ~oper_c);
        n_flush = 0;
        axw(`SARC_OFF_CTRL, 32'h2, `SARC_RESP_OKAY);
        rdc(`SARC_OFF_OPER_EVT, 32'h0, `SARC_RESP_OKAY);
        rdc(`SARC_OFF_IRQ_STAT, 32'h0, `SARC_RESP_OKAY);
        axw(`SARC_OFF_CTRL, 32'h1, `SARC_RESP_OKAY);
        // let the counting process see the last flush pulse first
        @(posedge clk);
        chk(32'(n_flush), 32'h2);
        $display("test clears done");
        for (g = 0; g < 2; g++) begin
            wq.delete();
            i_host.gap = g * 3;
            axw(`SARC_OFF_CTRL, 32'h20, `SARC_RESP_OKAY);
            for (k = 0; k < 4 - g; k++) begin
                wvq[k] = 16'($random(seed));
                i_host.send_word(wvq[k]);
            end
            repeat (4) @(posedge clk);
            axw(`SARC_OFF_CTRL, 32'h40, `SARC_RESP_OKAY);
            chk(32'(wq.size()), 32'(4 - g));
            foreach (wq[k]) chk(32'(wq[k]), 32'({k[9:0], wvq[k]}));
            rdc(`SARC_OFF_IRQ_STAT, (g != 0) ? 32'h8 : 32'h4, `SARC_RESP_OKAY);
            axw(`SARC_OFF_IRQ_STAT, 32'hF, `SARC_RESP_OKAY);
        end
        chk(32'(i_host.hangs), 32'h0);
        $display("test waveform done");
        print_verdict;
    end
endmodule
